/* File: sdram_pkg.sv */
// constants, types and decode helpers for the sdram bank state block
// assumes a 100 MHz system clock; all timing figures become cycle counts
package sdram_pkg;

  // ***************************************************************
  // clock and timing figures
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 10; // 100 MHz system clock
  localparam int PRECHARGE_TIME_NS = 20; // precharge_time
  localparam int ROW_TO_COLUMN_DELAY_NS = 20; // row_to_column_delay
  localparam int REFRESH_CYCLE_TIME_NS = 66; // refresh_cycle_time
  localparam int MODE_LOAD_DELAY_NS = 20; // mode_load_delay
  localparam int SELF_REFRESH_EXIT_TIME_NS = 75; // self_refresh_exit_time
  localparam int BURST_CYCLES_DEF = 8; // burst length in clocks
  localparam int SELF_REFRESH_PERIOD_NS = 15625; // internal refresh pace

  // least times round up, never below one cycle
  function automatic int min_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles

  localparam int CNT_W = 8; // width of the bank and mode timing down-counters
  localparam logic [CNT_W-1:0] PRECHARGE_CYC =
    CNT_W'(min_cycles(PRECHARGE_TIME_NS));
  localparam logic [CNT_W-1:0] ROW_TO_COLUMN_CYC =
    CNT_W'(min_cycles(ROW_TO_COLUMN_DELAY_NS));
  localparam logic [CNT_W-1:0] REFRESH_CYC =
    CNT_W'(min_cycles(REFRESH_CYCLE_TIME_NS));
  localparam logic [CNT_W-1:0] MODE_LOAD_CYC =
    CNT_W'(min_cycles(MODE_LOAD_DELAY_NS));
  localparam int SR_EXIT_RAW = min_cycles(SELF_REFRESH_EXIT_TIME_NS);
  // exit time is never shorter than two clocks
  localparam logic [CNT_W-1:0] SR_EXIT_CYC =
    CNT_W'((SR_EXIT_RAW < 2) ? 2 : SR_EXIT_RAW);
  localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_CYCLES_DEF);
  // longest interval rounds down
  localparam int OSC_W = 11; // width of the internal oscillator divider
  localparam logic [OSC_W-1:0] SR_PERIOD_CYC =
    OSC_W'(SELF_REFRESH_PERIOD_NS / CLK_PERIOD_NS);

  // ***************************************************************
  // sizes and reset values
  // ***************************************************************
  localparam int NUM_BANKS = 4;
  localparam int ROW_W = 12; // internal refresh row counter width
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [ROW_W-1:0] ROW_ZERO = 12'h000;
  localparam logic [ROW_W-1:0] ROW_ONE = 12'h001;
  localparam logic [OSC_W-1:0] OSC_ONE = 11'h001;

  // ***************************************************************
  // enumerations
  // ***************************************************************
  typedef enum logic [2:0] {
    BANK_IDLE = 3'b000,
    BANK_ACTIVATING = 3'b001,
    BANK_ROW_ACTIVE = 3'b010,
    BANK_READ = 3'b011,
    BANK_WRITE = 3'b100,
    BANK_READ_AP = 3'b101,
    BANK_WRITE_AP = 3'b110,
    BANK_PRECHARGING = 3'b111
  } bank_state_type;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_REFRESHING = 3'b001,
    MODE_MODE_ACCESS = 3'b010,
    MODE_PRECHARGE_ALL = 3'b011,
    MODE_SELF_REFRESH = 3'b100,
    MODE_SR_EXIT = 3'b101
  } mode_type;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_ACTIVATE = 3'b001,
    CMD_READ = 3'b010,
    CMD_WRITE = 3'b011,
    CMD_TERMINATE = 3'b100,
    CMD_PRECHARGE = 3'b101,
    CMD_REFRESH = 3'b110,
    CMD_MODE_LOAD = 3'b111
  } cmd_type;

  // command pin decode; deselect folds into no-operation
  function automatic cmd_type decode_cmd(input logic cs_n,
      input logic ras_n, input logic cas_n, input logic we_n);
    if (cs_n) begin
      return CMD_NOP;
    end
    unique case ({ras_n, cas_n, we_n})
      3'b111: return CMD_NOP;
      3'b011: return CMD_ACTIVATE;
      3'b101: return CMD_READ;
      3'b100: return CMD_WRITE;
      3'b110: return CMD_TERMINATE;
      3'b010: return CMD_PRECHARGE;
      3'b001: return CMD_REFRESH;
      default: return CMD_MODE_LOAD;
    endcase
  endfunction : decode_cmd

endpackage : sdram_pkg

/* File: sdram_bank_state.sv */
// per-bank command state and self refresh sequencing of an sdram
// assumes command pins and clock enable are synchronous to clk_i
`timescale 1ns/1ns
module sdram_bank_state #(
  parameter bit SELF_REFRESH_EN = 1'b1 // clear for automotive variant
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // command pins
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic auto_precharge_addr_bit_i,
  input wire logic bank_select_0_i,
  input wire logic bank_select_1_i,
  // state view
  output sdram_pkg::bank_state_type bank_state_o [sdram_pkg::NUM_BANKS],
  output sdram_pkg::mode_type mode_o,
  output logic [sdram_pkg::ROW_W-1:0] refresh_row_o,
  output logic refresh_pulse_o,
  output logic illegal_cmd_o
);
  import sdram_pkg::*;

  // ***************************************************************
  // command decode
  // ***************************************************************
  logic cke_prev; // clock enable from the previous edge
  logic next_cke_prev;
  cmd_type cmd; // decoded pins of this edge
  logic [1:0] target; // bank named by the bank selects
  logic cmd_live; // pins are meaningful on this edge
  logic all_idle; // every bank idle
  logic [NUM_BANKS-1:0] bank_idle;
  logic [NUM_BANKS-1:0] bank_pre_ok; // bank may be precharged
  logic [1:0] last_burst; // bank of most recent read or write
  logic [1:0] next_last_burst;
  logic pall; // precharge to every bank this edge
  logic [NUM_BANKS-1:0] bank_bad; // per-bank illegal command

  assign cmd = decode_cmd(cs_n_i, ras_n_i, cas_n_i, we_n_i);
  assign target = {bank_select_1_i, bank_select_0_i};
  assign all_idle = &bank_idle;
  // only in normal mode with cke high on both edges
  assign cmd_live = (mode_o == MODE_NORMAL) && cke_prev && cke_i;
  // address bit ten high means all banks, bank selects ignored
  assign pall = cmd_live && (cmd == CMD_PRECHARGE) &&
                auto_precharge_addr_bit_i;

  // ***************************************************************
  // per-bank state machines
  // ***************************************************************
  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      bank_state_type next_state;
      logic [CNT_W-1:0] cnt; // time left in a timed state
      logic [CNT_W-1:0] next_cnt;
      logic hit; // this edge's command aims at this bank
      logic cnt_done;

      assign hit = cmd_live && (target == 2'(b));
      assign cnt_done = (cnt == CNT_ONE);
      assign bank_idle[b] = (bank_state_o[b] == BANK_IDLE);
      assign bank_pre_ok[b] = (bank_state_o[b] == BANK_IDLE) ||
                              (bank_state_o[b] == BANK_ROW_ACTIVE) ||
                              (bank_state_o[b] == BANK_READ) ||
                              (bank_state_o[b] == BANK_WRITE);

      // next state: timers first, then commands aimed at this bank
      always_comb begin
        next_state = bank_state_o[b];
        next_cnt = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_ONE;
        bank_bad[b] = 1'b0;
        unique case (bank_state_o[b])
          BANK_ACTIVATING: begin
            if (cnt_done) begin
              next_state = BANK_ROW_ACTIVE;
            end
          end
          BANK_PRECHARGING, BANK_READ_AP, BANK_WRITE_AP: begin
            if (cnt_done) begin
              next_state = BANK_IDLE;
            end
          end
          BANK_READ, BANK_WRITE: begin
            if (cnt_done) begin
              next_state = BANK_ROW_ACTIVE; // burst ran out
            end
          end
          default: begin
          end
        endcase
        if (pall) begin
          // every bank closes together
          next_state = BANK_PRECHARGING;
          next_cnt = PRECHARGE_CYC;
        end else if (cmd_live && cmd == CMD_TERMINATE &&
                     last_burst == 2'(b) &&
                     (bank_state_o[b] == BANK_READ ||
                      bank_state_o[b] == BANK_WRITE)) begin
          next_state = BANK_ROW_ACTIVE;
          next_cnt = CNT_ZERO;
        end else if (hit) begin
          unique case (bank_state_o[b])
            BANK_IDLE: begin
              if (cmd == CMD_ACTIVATE) begin
                next_state = BANK_ACTIVATING;
                next_cnt = ROW_TO_COLUMN_CYC;
              end else if (cmd == CMD_READ || cmd == CMD_WRITE) begin
                bank_bad[b] = 1'b1;
              end
              // precharge to an idle bank is a no-op
            end
            BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE: begin
              if (cmd == CMD_READ || cmd == CMD_WRITE) begin
                next_state = auto_precharge_addr_bit_i ?
                  ((cmd == CMD_READ) ? BANK_READ_AP : BANK_WRITE_AP) :
                  ((cmd == CMD_READ) ? BANK_READ : BANK_WRITE);
                next_cnt = auto_precharge_addr_bit_i ? PRECHARGE_CYC
                                                     : BURST_CYC;
              end else if (cmd == CMD_PRECHARGE) begin
                // truncates a running burst
                next_state = BANK_PRECHARGING;
                next_cnt = PRECHARGE_CYC;
              end else if (cmd == CMD_ACTIVATE) begin
                bank_bad[b] = 1'b1;
              end
            end
            default: begin
              // busy bank: activate, read, write or precharge is a violation
              bank_bad[b] = (cmd != CMD_NOP) &&
                            (cmd != CMD_TERMINATE) &&
                            (cmd != CMD_REFRESH) &&
                            (cmd != CMD_MODE_LOAD);
            end
          endcase
        end
        // a no-op or deselect falls through, leaving timers running
      end

      // register the bank state and its timer
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          bank_state_o[b] <= BANK_IDLE;
          cnt <= CNT_ZERO;
        end else begin
          bank_state_o[b] <= next_state;
          cnt <= next_cnt;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // device-wide mode, refresh counter and internal oscillator
  // ***************************************************************
  mode_type next_mode;
  logic [CNT_W-1:0] mcnt; // time left in a device-wide state
  logic [CNT_W-1:0] next_mcnt;
  logic [OSC_W-1:0] osc; // internal refresh pacing divider
  logic [OSC_W-1:0] next_osc;
  logic osc_tick; // enable from the divider, high while osc is one; one cycle per period in self refresh
  logic [ROW_W-1:0] next_row;
  logic next_pulse;
  logic next_illegal;
  logic sr_enter; // self refresh entry on this edge

  assign osc_tick = (osc == OSC_ONE);
  // same pins as refresh, cke falling; absent on the variant
  assign sr_enter = SELF_REFRESH_EN && (mode_o == MODE_NORMAL) &&
                    cke_prev && !cke_i && (cmd == CMD_REFRESH) &&
                    all_idle;

  // next mode: sequences, refresh pacing and violation flag
  always_comb begin
    next_mode = mode_o;
    next_mcnt = (mcnt == CNT_ZERO) ? CNT_ZERO : mcnt - CNT_ONE;
    next_osc = osc;
    next_row = refresh_row_o;
    next_pulse = 1'b0;
    next_illegal = |bank_bad;
    next_cke_prev = cke_i;
    next_last_burst = last_burst;
    unique case (mode_o)
      MODE_NORMAL: begin
        if (sr_enter) begin
          next_mode = MODE_SELF_REFRESH;
          next_osc = SR_PERIOD_CYC;
        end else if (cmd_live && cmd == CMD_REFRESH) begin
          if (all_idle) begin
            next_mode = MODE_REFRESHING;
            next_mcnt = REFRESH_CYC;
            next_row = refresh_row_o + ROW_ONE;
            next_pulse = 1'b1;
          end else begin
            next_illegal = 1'b1;
          end
        end else if (cmd_live && cmd == CMD_MODE_LOAD) begin
          if (all_idle) begin
            next_mode = MODE_MODE_ACCESS;
            next_mcnt = MODE_LOAD_CYC;
          end else begin
            next_illegal = 1'b1;
          end
        end else if (pall) begin
          next_mode = MODE_PRECHARGE_ALL;
          next_mcnt = PRECHARGE_CYC;
          // a bank busy with its own timing is still closed, but flagged illegal
          next_illegal = !(&bank_pre_ok);
        end else if (cmd_live && (cmd == CMD_READ || cmd == CMD_WRITE)
                     && !bank_bad[target]) begin
          next_last_burst = target; // remembered for terminate
        end
      end
      MODE_REFRESHING, MODE_MODE_ACCESS, MODE_PRECHARGE_ALL,
      MODE_SR_EXIT: begin
        // pins are checked for no-ops only
        next_illegal = cke_i && (cmd != CMD_NOP);
        if (mcnt == CNT_ONE) begin
          next_mode = MODE_NORMAL;
        end
      end
      MODE_SELF_REFRESH: begin
        // only cke is watched; refresh paced internally
        next_osc = osc_tick ? SR_PERIOD_CYC : osc - OSC_ONE;
        if (osc_tick) begin
          next_row = refresh_row_o + ROW_ONE;
          next_pulse = 1'b1;
        end
        if (cke_i) begin
          // an internal refresh may still be under way
          next_mode = MODE_SR_EXIT;
          next_mcnt = SR_EXIT_CYC;
        end
      end
      default: begin
        next_mode = MODE_NORMAL; // unused codes recover
      end
    endcase
  end

  // register device-wide state
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_o <= MODE_NORMAL;
      mcnt <= CNT_ZERO;
      osc <= OSC_ONE;
      refresh_row_o <= ROW_ZERO;
      refresh_pulse_o <= 1'b0;
      illegal_cmd_o <= 1'b0;
      cke_prev <= 1'b0;
      last_burst <= 2'b00;
    end else begin
      mode_o <= next_mode;
      mcnt <= next_mcnt;
      osc <= next_osc;
      refresh_row_o <= next_row;
      refresh_pulse_o <= next_pulse;
      illegal_cmd_o <= next_illegal;
      cke_prev <= next_cke_prev;
      last_burst <= next_last_burst;
    end
  end

endmodule : sdram_bank_state

/* File: sdram_bank_state_asserts.sv */
// checker for bank state timing and self refresh sequencing
// sees only the ports of sdram_bank_state; bound to every instance
`timescale 1ns/1ns
module sdram_bank_state_chk
  import sdram_pkg::*;
#(
  parameter bit SELF_REFRESH_EN = 1'b1 // clear for automotive variant
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // command pins
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic auto_precharge_addr_bit_i,
  input wire logic bank_select_0_i,
  input wire logic bank_select_1_i,
  // state view
  input sdram_pkg::bank_state_type bank_state_o [sdram_pkg::NUM_BANKS],
  input sdram_pkg::mode_type mode_o,
  input wire logic [sdram_pkg::ROW_W-1:0] refresh_row_o,
  input wire logic refresh_pulse_o,
  input wire logic illegal_cmd_o
);
  // ***************************************************************
  // helper decode
  // ***************************************************************
  logic cke_prev; // cke at the previous edge, low out of reset
  logic next_cke_prev;
  logic [2:0] pins; // ras, cas, we; deselect folds into no-op
  logic [1:0] bk; // addressed bank
  logic taken; // a command counts on this edge
  logic all_idle;
  always_comb next_cke_prev = cke_i;
  // registered so a cke low edge blocks the next command too
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cke_prev <= 1'b0;
    end else begin
      cke_prev <= next_cke_prev;
    end
  end
  assign pins = cs_n_i ? 3'h7 : {ras_n_i, cas_n_i, we_n_i};
  assign bk = {bank_select_1_i, bank_select_0_i};
  assign taken = (mode_o == MODE_NORMAL) && cke_i && cke_prev;
  assign all_idle = bank_state_o[0] == BANK_IDLE &&
    bank_state_o[1] == BANK_IDLE && bank_state_o[2] == BANK_IDLE &&
    bank_state_o[3] == BANK_IDLE;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ***************************************************************
  // per bank timing
  // ***************************************************************
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    property p_act;
      taken && pins == 3'h3 && bk == 2'(b) && bank_state_o[b] == BANK_IDLE
      |=> (bank_state_o[b] == BANK_ACTIVATING) [*2]
      ##1 bank_state_o[b] == BANK_ROW_ACTIVE;
    endproperty
    a_act: assert property (p_act) else $error("activate timing");
    property p_ap;
      taken && pins inside {3'h4, 3'h5} && auto_precharge_addr_bit_i &&
      bk == 2'(b) && bank_state_o[b] == BANK_ROW_ACTIVE
      |=> (bank_state_o[b] inside {BANK_READ_AP, BANK_WRITE_AP}) [*2]
      ##1 bank_state_o[b] == BANK_IDLE;
    endproperty
    a_ap: assert property (p_ap) else $error("auto precharge");
    property p_pre;
      taken && pins == 3'h2 && !auto_precharge_addr_bit_i && bk == 2'(b)
      && bank_state_o[b] inside {BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE}
      |=> (bank_state_o[b] == BANK_PRECHARGING) [*2]
      ##1 bank_state_o[b] == BANK_IDLE;
    endproperty
    a_pre: assert property (p_pre) else $error("precharge");
  end
  // ***************************************************************
  // device modes
  // ***************************************************************
  property p_ref;
    taken && pins == 3'h1 && all_idle
    |=> (mode_o == MODE_REFRESHING) [*7] ##1 mode_o == MODE_NORMAL;
  endproperty
  a_ref: assert property (p_ref) else $error("refresh");
  property p_mrs;
    taken && pins == 3'h0 && all_idle
    |=> (mode_o == MODE_MODE_ACCESS) [*2] ##1 mode_o == MODE_NORMAL;
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode load");
  property p_pall;
    taken && pins == 3'h2 && auto_precharge_addr_bit_i
    |=> (mode_o == MODE_PRECHARGE_ALL) [*2] ##1 all_idle;
  endproperty
  a_pall: assert property (p_pall) else $error("precharge all");
  property p_sr_in;
    mode_o == MODE_NORMAL && cke_prev && !cke_i && pins == 3'h1 &&
    all_idle |=> mode_o == (SELF_REFRESH_EN ? MODE_SELF_REFRESH :
    MODE_NORMAL);
  endproperty
  a_sr_in: assert property (p_sr_in) else $error("sr entry");
  property p_sr_hold;
    mode_o == MODE_SELF_REFRESH && !cke_i |=> mode_o == MODE_SELF_REFRESH;
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("sr hold");
  property p_sr_out;
    mode_o == MODE_SELF_REFRESH && cke_i
    |=> (mode_o == MODE_SR_EXIT) [*8] ##1 mode_o == MODE_NORMAL;
  endproperty
  a_sr_out: assert property (p_sr_out) else $error("sr exit");
  property p_bad;
    taken && pins == 3'h5 && bank_state_o[bk] == BANK_IDLE |=> illegal_cmd_o;
  endproperty
  a_bad: assert property (p_bad) else $error("illegal flag");
  property p_gate;
    mode_o == MODE_NORMAL && !cke_prev && pins == 3'h3 && all_idle
    |=> all_idle;
  endproperty
  a_gate: assert property (p_gate) else $error("cke gate");
  // main scenarios reached
  c_sr: cover property (mode_o == MODE_SELF_REFRESH);
  c_ref: cover property (mode_o == MODE_REFRESHING);
  c_pall: cover property (mode_o == MODE_PRECHARGE_ALL);
endmodule : sdram_bank_state_chk

bind sdram_bank_state sdram_bank_state_chk #(
  .SELF_REFRESH_EN(SELF_REFRESH_EN)
) u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
  .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
  .auto_precharge_addr_bit_i(auto_precharge_addr_bit_i),
  .bank_select_0_i(bank_select_0_i), .bank_select_1_i(bank_select_1_i),
  .bank_state_o(bank_state_o), .mode_o(mode_o),
  .refresh_row_o(refresh_row_o), .refresh_pulse_o(refresh_pulse_o),
  .illegal_cmd_o(illegal_cmd_o)
);

/* File: sdram_ctrl_model.sv */
// memory controller model driving the sdram command pins
// bench calls its tasks at falling edges; pins change only there
`timescale 1ns/1ns
module sdram_ctrl_model #(
  parameter int ROW_ACTIVE_MIN_CYC = 5 // least self refresh stay
) (
  // clock
  input wire logic clk_i,
  // command pins
  output logic cke_o,
  output logic cs_n_o,
  output logic [2:0] cmd_n_o, // ras, cas, we
  output logic ap_bit_o,
  output logic [1:0] bank_o
);
  // deselected and clock enabled at time zero
  initial begin
    cke_o = 1'b1;
    cs_n_o = 1'b1;
    cmd_n_o = 3'h7;
    ap_bit_o = 1'b0;
    bank_o = 2'h0;
  end
  // one command for the next edge, with cke driven from k
  task automatic issue(input logic [2:0] p, input logic [1:0] b,
      input logic a, input logic k);
    cke_o = k;
    cs_n_o = 1'b0;
    cmd_n_o = p;
    ap_bit_o = a;
    bank_o = b;
    @(negedge clk_i);
  endtask : issue
  // deselect; released lines flip so stale values never look valid
  task automatic idle(input int n);
    cs_n_o = 1'b1;
    cmd_n_o = ~cmd_n_o;
    ap_bit_o = ~ap_bit_o;
    bank_o = ~bank_o;
    repeat (n) @(negedge clk_i);
  endtask : idle
  // clock keeps running, so cke may rise once the stay is long enough
  task automatic wake(input int stay);
    repeat ((stay < ROW_ACTIVE_MIN_CYC) ? ROW_ACTIVE_MIN_CYC : stay)
      @(negedge clk_i);
    cke_o = 1'b1;
    @(negedge clk_i);
  endtask : wake
endmodule : sdram_ctrl_model

/* File: tb_sdram_bank_state.sv */
// self-checking bench for sdram_bank_state
// drives two instances (with and without self refresh) from one model
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb_sdram_bank_state;
  import sdram_pkg::*;
  // pin codes ras, cas, we
  localparam logic [2:0] ACT = 3'h3;
  localparam logic [2:0] RD = 3'h5;
  localparam logic [2:0] WR = 3'h4;
  localparam logic [2:0] BT = 3'h6;
  localparam logic [2:0] PRE = 3'h2;
  localparam logic [2:0] REF = 3'h1;
  localparam logic [2:0] MRS = 3'h0;
  localparam logic [2:0] NOP = 3'h7;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cke, cs_n, ap_bit, pulse, illegal;
  logic [2:0] cmd_n;
  logic [1:0] bank;
  logic [ROW_W-1:0] row;
  logic [ROW_W-1:0] auto_row; // row counter of the variant
  logic auto_pulse, auto_ill; // pulses of the variant
  bank_state_type bank_st [NUM_BANKS];
  bank_state_type auto_st [NUM_BANKS];
  mode_type mode, auto_mode;
  int error_cnt = 0;
  int cmp_count = 0;
  int pulse_cnt = 0;
  always #5 clk = ~clk;
  // count refresh pulses as the device reports them
  always @(posedge clk) begin
    if (pulse === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
    end
  end
  sdram_ctrl_model ctl (
    .clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .cmd_n_o(cmd_n),
    .ap_bit_o(ap_bit), .bank_o(bank)
  );
  sdram_bank_state dut (
    .clk_i(clk), .reset_n_i(reset_n), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]),
    .auto_precharge_addr_bit_i(ap_bit), .bank_select_0_i(bank[0]),
    .bank_select_1_i(bank[1]), .bank_state_o(bank_st), .mode_o(mode),
    .refresh_row_o(row), .refresh_pulse_o(pulse), .illegal_cmd_o(illegal)
  );
  sdram_bank_state #(.SELF_REFRESH_EN(1'b0)) dut_auto (
    .clk_i(clk), .reset_n_i(reset_n), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]),
    .auto_precharge_addr_bit_i(ap_bit), .bank_select_0_i(bank[0]),
    .bank_select_1_i(bank[1]), .bank_state_o(auto_st), .mode_o(auto_mode),
    .refresh_row_o(auto_row), .refresh_pulse_o(auto_pulse),
    .illegal_cmd_o(auto_ill)
  );
  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // reset values, then a command right after a cke low edge
  task automatic t_reset_gate();
    for (int b = 0; b < NUM_BANKS; b++) begin
      `CHK(bank_st[b], BANK_IDLE)
    end
    `CHK(mode, MODE_NORMAL)
    ctl.issue(NOP, 2'h0, 1'b0, 1'b0);
    ctl.issue(ACT, 2'h0, 1'b0, 1'b1);
    `CHK(bank_st[0], BANK_IDLE)
    ctl.idle(1);
  endtask : t_reset_gate
  // bank walk: bursts, terminate, truncation, auto precharge
  task automatic t_bank_flow();
    ctl.issue(ACT, 2'h1, 1'b0, 1'b1);
    `CHK(bank_st[1], BANK_ACTIVATING)
    ctl.issue(ACT, 2'h2, 1'b0, 1'b1);
    `CHK(bank_st[1], BANK_ACTIVATING)
    ctl.idle(1);
    `CHK(bank_st[1], BANK_ROW_ACTIVE)
    ctl.issue(RD, 2'h1, 1'b0, 1'b1);
    `CHK(bank_st[1], BANK_READ)
    ctl.issue(WR, 2'h1, 1'b0, 1'b1);
    `CHK(bank_st[1], BANK_WRITE)
    ctl.issue(BT, 2'h0, 1'b0, 1'b1);
    `CHK(bank_st[1], BANK_ROW_ACTIVE)
    ctl.issue(RD, 2'h1, 1'b0, 1'b1);
    ctl.issue(PRE, 2'h1, 1'b0, 1'b1);
    `CHK(bank_st[1], BANK_PRECHARGING)
    ctl.issue(PRE, 2'h0, 1'b0, 1'b1);
    `CHK(bank_st[0], BANK_IDLE)
    ctl.idle(1);
    `CHK(bank_st[1], BANK_IDLE)
    `CHK(bank_st[2], BANK_ROW_ACTIVE)
    ctl.issue(REF, 2'h0, 1'b0, 1'b1);
    `CHK(mode, MODE_NORMAL)
    ctl.issue(WR, 2'h2, 1'b1, 1'b1);
    `CHK(bank_st[2], BANK_WRITE_AP)
    ctl.idle(2);
    `CHK(bank_st[2], BANK_IDLE)
    ctl.issue(RD, 2'h3, 1'b0, 1'b1);
    `CHK(illegal, 1'b1)
    `CHK(auto_ill, 1'b1)
    `CHK(bank_st[3], BANK_IDLE)
    ctl.idle(1);
    `CHK(illegal, 1'b0)
  endtask : t_bank_flow
  // refresh, mode load and precharge of all banks
  task automatic t_device_modes();
    logic [ROW_W-1:0] r0;
    int n0;
    r0 = row;
    n0 = pulse_cnt;
    ctl.issue(REF, 2'h0, 1'b0, 1'b1);
    `CHK(mode, MODE_REFRESHING)
    `CHK(pulse, 1'b1)
    `CHK(auto_pulse, 1'b1)
    ctl.idle(7);
    `CHK(mode, MODE_NORMAL)
    `CHK(row, r0 + ROW_ONE)
    ctl.issue(MRS, 2'h0, 1'b0, 1'b1);
    `CHK(mode, MODE_MODE_ACCESS)
    ctl.idle(2);
    `CHK(mode, MODE_NORMAL)
    `CHK(pulse_cnt, n0 + 1)
    ctl.issue(ACT, 2'h0, 1'b0, 1'b1);
    ctl.issue(ACT, 2'h3, 1'b0, 1'b1);
    ctl.idle(2);
    ctl.issue(PRE, 2'h1, 1'b1, 1'b1);
    `CHK(mode, MODE_PRECHARGE_ALL)
    `CHK(bank_st[3], BANK_PRECHARGING)
    ctl.idle(2);
    `CHK(bank_st[0], BANK_IDLE)
    `CHK(mode, MODE_NORMAL)
  endtask : t_device_modes
  // self refresh entry, ignored pins, internal refresh, exit
  task automatic t_self_refresh();
    logic [ROW_W-1:0] r0;
    r0 = row;
    ctl.issue(REF, 2'h0, 1'b0, 1'b0);
    `CHK(mode, MODE_SELF_REFRESH)
    `CHK(auto_mode, MODE_NORMAL)
    ctl.issue(ACT, 2'h1, 1'b0, 1'b0);
    ctl.idle(1);
    `CHK(bank_st[1], BANK_IDLE)
    ctl.wake(1600);
    `CHK(mode, MODE_SR_EXIT)
    `CHK(row, r0 + ROW_ONE)
    `CHK(auto_row, r0)
    ctl.idle(8);
    `CHK(mode, MODE_NORMAL)
    r0 = row;
    ctl.issue(REF, 2'h0, 1'b0, 1'b1);
    ctl.idle(7);
    `CHK(row, r0 + ROW_ONE)
  endtask : t_self_refresh
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    t_reset_gate();
    t_bank_flow();
    t_device_modes();
    t_self_refresh();
    ctl.idle(2);
    complete_run();
  end
  // whole run needs about 1660 cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule : tb_sdram_bank_state
